// ---- logic/ccfg_dcl_detect.sv ----
/*
 Measures the gci data clock period and flags the 4.096 MHz rate.
 Assumes dcl_s is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccfg_defs.svh"

module ccfg_dcl_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised data clock
    input wire logic dcl_s,
    // result
    output logic dcl_fast
);
    import ccfg_pkg::*;

    localparam logic [5:0] SPLIT = 6'(`CCFG_DCL_SPLIT_CYC);

    logic prev_q;
    logic prev_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic fast_q;
    logic fast_d;

    always_comb begin
        prev_d = dcl_s;
        cnt_d = (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
        fast_d = fast_q;
        if (dcl_s && !prev_q) begin
            // a stopped clock saturates the count; the flag holds until the next edge, which reads as slow
            fast_d = (cnt_q < SPLIT);
            cnt_d = 6'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
            cnt_q <= 6'h00;
            fast_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            fast_q <= fast_d;
        end
    end

    assign dcl_fast = fast_q;

endmodule : ccfg_dcl_detect

`default_nettype wire

// ---- logic/ccfg_regs.sv ----
/*
 Global configuration registers of a four-channel pcm codec, reached over
 the serial control port, with loopback muxes and conference gain.
 Assumes pins arrive asynchronously; core signals are on clk.
*/
//
// Behaviour
// - linear_code 0 picks 8-bit companded, 1 picks 16-bit linear.
// - a_law 0 picks mu-law, 1 A-law; A-law after reset.
// - double_bitclock_select picks single or double clock, serial mode only.
// - edge_select sets transmit and receive edges, serial mode only.
// - slot_offset delays time slots 0 to 7 bit clocks after frame_sync.
// - channel_program_enable bits gate later channel commands, all off.
// - master clock select code decodes to the listed frequencies.
// - gci mode takes master clock rate from measured gci_data_clock.
// - writing 1 to hard_reset_bit resets all like the reset pin.
// - soft_reset_bit resets only selected channel registers.
// - reset_channel_select bits pick the channels, cleared by default.
// - reading the reset register returns a fixed version code.
// - four loopback enables at high and low rate, all off.
// - highway loopbacks between transmit out and receive in, serial only.
// - internal and external conference enables, both off.
// - conference_channel_select codes 00..11 pick channels 1..4.
// - conference path scaled by conference_gain_value over 256.
`timescale 1ns/1ps
`default_nettype none
`include "ccfg_defs.svh"

module ccfg_regs #(
    // arbitrary value, not a real part's code
    parameter logic [7:0] VERSION = 8'h3C
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // mode strap, high selects gci
    input wire logic gci_mode_pin,
    // serial control port
    input wire logic scp_cs_n,
    input wire logic scp_sclk,
    input wire logic scp_sdi,
    output logic scp_sdo,
    output logic scp_sdo_oe_n,
    // gci data clock
    input wire logic gci_data_clock,
    // pcm highway
    input wire logic pcm_receive_in,
    output logic pcm_transmit_out,
    input wire logic core_tx_bit,
    output logic core_rx_bit,
    // conference path
    input wire logic signed [15:0] conf_sample,
    output logic signed [15:0] conf_scaled,
    // configuration
    output ccfg_pkg::ccfg_cfg_t cfg,
    output logic [13:0] mclk_khz,
    output logic hard_reset,
    output logic soft_reset,
    output logic [3:0] soft_reset_chan
);
    import ccfg_pkg::*;

    function automatic logic [13:0] mclk_decode(input logic [3:0] sel);
        unique case (sel)
            4'h0: mclk_decode = 14'h2000;
            4'h1: mclk_decode = 14'h1000;
            4'h2: mclk_decode = 14'h0800;
            4'h6: mclk_decode = 14'h0600;
            4'hE: mclk_decode = 14'h0608;
            // 0101 is printed twice; 3.072 MHz taken
            4'h5: mclk_decode = 14'h0C00;
            4'h4: mclk_decode = 14'h1800;
            4'hC: mclk_decode = 14'h1820;
            default: mclk_decode = 14'h0000;
        endcase
    endfunction : mclk_decode

    logic [4:0] pins_s;
    logic gci_s;
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic rx_s;
    logic dcl_fast;
    logic dcl_s;
    logic rst_all;

    ccfg_sync #(.W(5)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({gci_mode_pin, scp_cs_n, scp_sclk, scp_sdi, pcm_receive_in}),
        .sync_out(pins_s)
    );
    assign {gci_s, cs_n_s, sclk_s, sdi_s, rx_s} = pins_s;

    ccfg_sync #(.W(1)) u_dcl_sync (
        .clk(clk),
        .rst(rst),
        .async_in(gci_data_clock),
        .sync_out(dcl_s)
    );

    ccfg_dcl_detect u_dcl_det (
        .clk(clk),
        .rst(rst_all),
        .dcl_s(dcl_s),
        .dcl_fast(dcl_fast)
    );

    // serial control port state
    ccfg_state_t st_q;
    ccfg_state_t st_d;
    logic sclk_p_q;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [6:0] sh_q;
    logic [6:0] sh_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic [7:0] out_q;
    logic [7:0] out_d;
    logic sdo_q;
    logic sdo_d;
    logic oe_n_q;
    logic oe_n_d;
    logic wr_fire;
    logic rd_load;
    logic [7:0] wr_data;
    logic rise;
    logic fall;

    // stored registers
    logic [7:0] pcm_q, pcm_d, mclk_q, mclk_d, loop_q, loop_d;
    logic [7:0] conf_q, conf_d, gain_q, gain_d;
    logic hard_q, hard_d, soft_q, soft_d;
    logic [3:0] chan_q, chan_d;

    // outputs
    ccfg_cfg_t cfg_q, cfg_d;
    logic [13:0] khz_q, khz_d;
    logic tx_q, tx_d, crx_q, crx_d;
    logic signed [15:0] cs_q, cs_d;
    logic signed [24:0] prod;

    assign rst_all = rst | hard_q;
    assign rise = sclk_s & ~sclk_p_q;
    assign fall = ~sclk_s & sclk_p_q;
    assign wr_data = {sh_q, sdi_s};

    function automatic logic [7:0] read_mux(input logic [6:0] a);
        unique case (a)
            `CCFG_OFS_PCM: read_mux = pcm_q;
            `CCFG_OFS_MCLK: read_mux = mclk_q;
            `CCFG_OFS_RST: read_mux = VERSION;
            `CCFG_OFS_LOOP: read_mux = loop_q;
            `CCFG_OFS_CONF: read_mux = conf_q;
            `CCFG_OFS_GAIN: read_mux = gain_q;
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // command byte then one data byte, msb first, sampled on sclk rise
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        out_d = out_q;
        sdo_d = sdo_q;
        oe_n_d = oe_n_q;
        wr_fire = 1'b0;
        rd_load = 1'b0;
        if (cs_n_s) begin
            st_d = CCFG_ST_CMD;
            cnt_d = 3'h0;
            oe_n_d = 1'b1;
        end else if (rise && st_q != CCFG_ST_DONE) begin
            sh_d = wr_data[6:0];
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7 && st_q == CCFG_ST_CMD) begin
                st_d = CCFG_ST_DATA;
                cmd_d = wr_data;
                rd_load = !wr_data[`CCFG_CMD_WRITE];
                if (rd_load) begin
                    out_d = read_mux(wr_data[6:0]);
                end
            end else if (cnt_q == 3'h7) begin
                st_d = CCFG_ST_DONE;
                wr_fire = cmd_q[`CCFG_CMD_WRITE];
                oe_n_d = 1'b1;
            end
        end else if (fall && st_q == CCFG_ST_DATA
                     && !cmd_q[`CCFG_CMD_WRITE]) begin
            // drive on the fall so the host samples a settled bit
            sdo_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
            oe_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            st_q <= CCFG_ST_CMD;
            sclk_p_q <= 1'b0;
            cnt_q <= 3'h0;
            sh_q <= 7'h00;
            cmd_q <= 8'h00;
            out_q <= 8'h00;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sclk_p_q <= sclk_s;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            cmd_q <= cmd_d;
            out_q <= out_d;
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
        end
    end

    // register writes; reset bits never stored
    always_comb begin
        pcm_d = pcm_q;
        mclk_d = mclk_q;
        loop_d = loop_q;
        conf_d = conf_q;
        gain_d = gain_q;
        hard_d = 1'b0;
        soft_d = 1'b0;
        chan_d = chan_q;
        if (wr_fire) begin
            unique case (cmd_q[6:0])
                `CCFG_OFS_PCM: pcm_d = wr_data;
                `CCFG_OFS_MCLK: mclk_d = wr_data;
                `CCFG_OFS_RST: begin
                    hard_d = wr_data[`CCFG_B_HARD];
                    soft_d = wr_data[`CCFG_B_SOFT]
                             & ~wr_data[`CCFG_B_HARD];
                    if (soft_d) begin
                        chan_d = wr_data[`CCFG_F_RCHAN];
                    end
                end
                `CCFG_OFS_LOOP: loop_d = wr_data & `CCFG_LOOP_MASK;
                `CCFG_OFS_CONF: conf_d = wr_data & `CCFG_CONF_MASK;
                `CCFG_OFS_GAIN: gain_d = wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            pcm_q <= `CCFG_PCM_RST;
            mclk_q <= `CCFG_MCLK_RST;
            loop_q <= `CCFG_ZERO_RST;
            conf_q <= `CCFG_ZERO_RST;
            gain_q <= `CCFG_ZERO_RST;
            hard_q <= 1'b0;
            soft_q <= 1'b0;
            chan_q <= 4'h0;
        end else begin
            pcm_q <= pcm_d;
            mclk_q <= mclk_d;
            loop_q <= loop_d;
            conf_q <= conf_d;
            gain_q <= gain_d;
            hard_q <= hard_d;
            soft_q <= soft_d;
            chan_q <= chan_d;
        end
    end

    // effective configuration; serial-only fields idle in gci mode
    always_comb begin
        cfg_d.linear_code = pcm_q[`CCFG_B_LINEAR];
        cfg_d.a_law = pcm_q[`CCFG_B_ALAW];
        cfg_d.double_bitclock_select = !gci_s & pcm_q[`CCFG_B_DBLCLK];
        cfg_d.edge_select = gci_s ? 2'h0 : pcm_q[`CCFG_F_EDGE];
        cfg_d.slot_offset = gci_s ? 3'h0 : pcm_q[`CCFG_F_OFFSET];
        cfg_d.channel_program_enable =
            gci_s ? 4'h0 : mclk_q[`CCFG_F_CHEN];
        cfg_d.analog_loop_high_rate = loop_q[`CCFG_B_ALB_HI];
        cfg_d.analog_loop_low_rate = loop_q[`CCFG_B_ALB_LO];
        cfg_d.analog_loop_highway = !gci_s & loop_q[`CCFG_B_ALB_HW];
        cfg_d.digital_loop_high_rate = loop_q[`CCFG_B_DLB_HI];
        cfg_d.digital_loop_low_rate = loop_q[`CCFG_B_DLB_LO];
        cfg_d.digital_loop_highway = !gci_s & loop_q[`CCFG_B_DLB_HW];
        cfg_d.internal_conference_enable = conf_q[`CCFG_B_CONF_INT];
        cfg_d.external_conference_enable = conf_q[`CCFG_B_CONF_EXT];
        cfg_d.conference_channel_select = conf_q[`CCFG_F_CONF_CH];
        cfg_d.conference_gain_value = gain_q;
        khz_d = gci_s ? (dcl_fast ? 14'h1000 : 14'h0800)
                      : mclk_decode(mclk_q[`CCFG_F_MCLK]);
        tx_d = cfg_q.digital_loop_highway ? rx_s : core_tx_bit;
        crx_d = cfg_q.analog_loop_highway ? core_tx_bit : rx_s;
        prod = conf_sample * $signed({1'b0, gain_q});
        cs_d = prod[23:8];
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            cfg_q <= '0;
            khz_q <= 14'h0000;
            tx_q <= 1'b0;
            crx_q <= 1'b0;
            cs_q <= 16'sh0000;
        end else begin
            cfg_q <= cfg_d;
            khz_q <= khz_d;
            tx_q <= tx_d;
            crx_q <= crx_d;
            cs_q <= cs_d;
        end
    end

    assign scp_sdo = sdo_q;
    assign scp_sdo_oe_n = oe_n_q;
    assign pcm_transmit_out = tx_q;
    assign core_rx_bit = crx_q;
    assign conf_scaled = cs_q;
    assign cfg = cfg_q;
    assign mclk_khz = khz_q;
    assign hard_reset = hard_q;
    assign soft_reset = soft_q;
    assign soft_reset_chan = chan_q;

    property p_hard;
        @(posedge clk) disable iff (rst)
        wr_fire && cmd_q[6:0] == `CCFG_OFS_RST && wr_data[7] |=> hard_q;
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset missed");
    property p_pulse;
        @(posedge clk) disable iff (rst)
        hard_q || soft_q |=> !hard_q && !soft_q;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset not a pulse");
    property p_soft;
        @(posedge clk) disable iff (rst_all)
        wr_fire && cmd_q[6:0] == `CCFG_OFS_RST && wr_data[5] && !wr_data[7]
        |=> soft_q && chan_q == $past(wr_data[3:0]);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");
    property p_ver;
        @(posedge clk) disable iff (rst_all)
        rd_load && wr_data[6:0] == `CCFG_OFS_RST |=> out_q == VERSION;
    endproperty
    a_ver: assert property (p_ver) else $error("version not loaded");
    property p_law;
        @(posedge clk) disable iff (rst_all)
        wr_fire && cmd_q[6:0] == `CCFG_OFS_PCM
        |=> ##1 cfg_q.a_law == $past(wr_data[6], 2);
    endproperty
    a_law: assert property (p_law) else $error("law bit wrong");
    property p_gci;
        @(posedge clk) disable iff (rst_all)
        gci_s |=> !cfg_q.double_bitclock_select && cfg_q.edge_select == 2'h0
                  && cfg_q.channel_program_enable == 4'h0;
    endproperty
    a_gci: assert property (p_gci) else $error("serial field in gci");
    property p_gclk;
        @(posedge clk) disable iff (rst_all)
        gci_s |=> khz_q == 14'h0800 || khz_q == 14'h1000;
    endproperty
    a_gclk: assert property (p_gclk) else $error("gci clock rate");
    property p_dflt;
        @(posedge clk) disable iff (rst)
        hard_q ##1 !hard_q |=> cfg_q.a_law && !cfg_q.linear_code
            && cfg_q.conference_gain_value == 8'h00;
    endproperty
    a_dflt: assert property (p_dflt) else $error("bad defaults");
    property p_dlb;
        @(posedge clk) disable iff (rst_all)
        cfg_q.digital_loop_highway |=> tx_q == $past(rx_s);
    endproperty
    a_dlb: assert property (p_dlb) else $error("loop path wrong");
    property p_gain;
        @(posedge clk) disable iff (rst_all)
        1'b1 |=> cs_q == $past(prod[23:8]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain wrong");
    c_write: cover property (@(posedge clk) wr_fire);
    c_read: cover property (@(posedge clk) rd_load ##[1:400] fall);
    c_hard: cover property (@(posedge clk) hard_q);
    c_soft: cover property (@(posedge clk) soft_q);

endmodule : ccfg_regs

`default_nettype wire

// ---- logic/ccfg_sync.sv ----
/*
 Two-flop synchroniser for a group of level inputs.
 Assumes each bit changes slowly against clk; no word coherence.
*/
`timescale 1ns/1ps
`default_nettype none

module ccfg_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import ccfg_pkg::*;

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : ccfg_sync

`default_nettype wire

// ---- pkg/ccfg_defs.svh ----
/*
 Offsets, field positions, reset values and timing counts of the codec
 global configuration registers.
 Assumes the includer works in clock cycles of the 40 MHz system clock.
*/
`ifndef CCFG_DEFS_SVH
`define CCFG_DEFS_SVH

// register codes, low seven bits of the command byte
`define CCFG_OFS_PCM 7'h22
`define CCFG_OFS_MCLK 7'h23
`define CCFG_OFS_RST 7'h24
`define CCFG_OFS_LOOP 7'h25
`define CCFG_OFS_CONF 7'h26
`define CCFG_OFS_GAIN 7'h27

// command byte
`define CCFG_CMD_WRITE 7

// pcm format fields
`define CCFG_B_LINEAR 7
`define CCFG_B_ALAW 6
`define CCFG_B_DBLCLK 5
`define CCFG_F_EDGE 4:3
`define CCFG_F_OFFSET 2:0

// master clock and channel enable fields
`define CCFG_F_CHEN 7:4
`define CCFG_F_MCLK 3:0

// reset control fields
`define CCFG_B_HARD 7
`define CCFG_B_SOFT 5
`define CCFG_F_RCHAN 3:0

// loopback fields
`define CCFG_B_ALB_HI 6
`define CCFG_B_ALB_LO 5
`define CCFG_B_ALB_HW 4
`define CCFG_B_DLB_HI 2
`define CCFG_B_DLB_LO 1
`define CCFG_B_DLB_HW 0

// conference fields
`define CCFG_B_CONF_INT 3
`define CCFG_B_CONF_EXT 2
`define CCFG_F_CONF_CH 1:0

// reset values and writable masks
`define CCFG_PCM_RST 8'h40
`define CCFG_MCLK_RST 8'h02
`define CCFG_ZERO_RST 8'h00
`define CCFG_LOOP_MASK 8'h77
`define CCFG_CONF_MASK 8'h0F

// gci data clock: period split between 2.048 and 4.096 MHz
`define CCFG_CLK_PERIOD_NS 25
`define CCFG_DCL_SPLIT_NS 366
`define CCFG_DCL_SPLIT_CYC (`CCFG_DCL_SPLIT_NS / `CCFG_CLK_PERIOD_NS)

`endif

// ---- pkg/ccfg_pkg.sv ----
/*
 Types shared by the codec global configuration logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package ccfg_pkg;

    typedef struct packed {
        logic linear_code;
        logic a_law;
        logic double_bitclock_select;
        logic [1:0] edge_select;
        logic [2:0] slot_offset;
        logic [3:0] channel_program_enable;
        logic analog_loop_high_rate;
        logic analog_loop_low_rate;
        logic analog_loop_highway;
        logic digital_loop_high_rate;
        logic digital_loop_low_rate;
        logic digital_loop_highway;
        logic internal_conference_enable;
        logic external_conference_enable;
        logic [1:0] conference_channel_select;
        logic [7:0] conference_gain_value;
    } ccfg_cfg_t;

    typedef enum logic [1:0] {
        CCFG_ST_CMD,
        CCFG_ST_DATA,
        CCFG_ST_DONE
    } ccfg_state_t;

endpackage : ccfg_pkg

`default_nettype wire

// ---- tb/ccfg_host.sv ----
/*
 Host model that drives the serial control port of the configuration block.
 Assumes the bench resolves the sdo line and clk runs at 40 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module ccfg_host (
    // clock
    input wire logic clk,
    // serial control port
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo_line
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // 4 clk per half gives 200 ns; sclk stands still low between frames
    task automatic half;
        repeat (4) @(posedge clk);
    endtask : half

    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
            output logic [7:0] rd);
        logic [15:0] word;
        word = {cmd, wd};
        rd = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            sdi <= word[15 - i];
            half();
            sclk <= 1'b1;
            repeat (2) @(posedge clk);
            // sample mid high phase, ahead of the enable release
            @(negedge clk);
            if (i >= 8) begin
                rd[15 - i] = sdo_line;
            end
            repeat (2) @(posedge clk);
            sclk <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        sdi <= ~sdi;
        half();
        half();
    endtask : xfer
endmodule : ccfg_host

`default_nettype wire

// ---- tb/test_codec_global_config_regs.sv ----
/*
 Self-checking bench for the codec global configuration registers.
 Assumes the register block, its package and the host model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module test_codec_global_config_regs;
    import ccfg_pkg::*;
    logic clk, rst, gci_mode, cs_n, sclk, sdi, sdo, oe_n, dcl, rx_in, tx_out;
    logic core_tx, core_rx, hard_reset, soft_reset;
    logic signed [15:0] conf_sample, conf_scaled;
    ccfg_cfg_t cfg;
    logic [13:0] mclk_khz;
    logic [3:0] soft_reset_chan;
    wire logic sdo_line;
    int fail_count, n_tests, dcl_half, dcl_cnt, hr_n, sr_n;
    logic [3:0] mc [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'hE, 4'h5, 4'h4,
        4'hC, 4'h3};
    logic [15:0] mk [9] = '{16'h2000, 16'h1000, 16'h0800, 16'h0600,
        16'h0608, 16'h0C00, 16'h1800, 16'h1820, 16'h0000};
    logic [1:0] e;

    // released line idles high through a pull-up
    assign sdo_line = oe_n ? 1'b1 : sdo;

    ccfg_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo_line(sdo_line));

    ccfg_regs u_dut (.clk(clk), .rst(rst), .gci_mode_pin(gci_mode),
        .scp_cs_n(cs_n), .scp_sclk(sclk), .scp_sdi(sdi), .scp_sdo(sdo),
        .scp_sdo_oe_n(oe_n), .gci_data_clock(dcl), .pcm_receive_in(rx_in),
        .pcm_transmit_out(tx_out), .core_tx_bit(core_tx),
        .core_rx_bit(core_rx), .conf_sample(conf_sample),
        .conf_scaled(conf_scaled), .cfg(cfg), .mclk_khz(mclk_khz),
        .hard_reset(hard_reset), .soft_reset(soft_reset),
        .soft_reset_chan(soft_reset_chan));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // gci clock counted off clk: 5 gives 250 ns, 10 gives 500 ns
    always @(posedge clk) begin
        if (dcl_cnt >= dcl_half - 1) begin
            dcl_cnt <= 0;
            dcl <= ~dcl;
        end else begin
            dcl_cnt <= dcl_cnt + 1;
        end
        if (hard_reset === 1'b1) begin
            hr_n <= hr_n + 1;
        end
        if (soft_reset === 1'b1) begin
            sr_n <= sr_n + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer({1'b1, a}, d, r);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        u_host.xfer({1'b0, a}, 8'h00, r);
        check({8'h00, r}, {8'h00, exp});
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic print_verdict;
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #1000000;
        fail_count++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        gci_mode = 1'b0;
        dcl = 1'b0;
        dcl_half = 5;
        dcl_cnt = 0;
        hr_n = 0;
        sr_n = 0;
        rx_in = 1'b0;
        core_tx = 1'b0;
        conf_sample = 16'sh0000;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle(6);
        check({15'h0000, cfg.a_law}, 16'h0001);
        check({2'b00, mclk_khz}, 16'h0800);
        rd(7'h22, 8'h40);
        rd(7'h23, 8'h02);
        rd(7'h24, 8'h3C);
        rd(7'h25, 8'h00);
        rd(7'h26, 8'h00);
        rd(7'h27, 8'h00);
        for (int i = 0; i < 4; i++) begin
            e = 2'(i);
            wr(7'h22, {e[0], ~e[0], e[1], e, 1'b1, e});
            rd(7'h22, {e[0], ~e[0], e[1], e, 1'b1, e});
            check({8'h00, cfg[29:22]}, {8'h00, e[0], ~e[0], e[1], e, 1'b1,
                e});
        end
        for (int i = 0; i < 9; i++) begin
            wr(7'h23, {mc[i] ^ 4'hA, mc[i]});
            check({2'b00, mclk_khz}, mk[i]);
            check({12'h000, cfg.channel_program_enable},
                {12'h000, mc[i] ^ 4'hA});
        end
        wr(7'h25, 8'h77);
        rd(7'h25, 8'h77);
        check({10'h000, cfg[17:12]}, 16'h003F);
        wr(7'h25, 8'h11);
        @(posedge clk);
        rx_in <= 1'b1;
        core_tx <= 1'b0;
        settle(6);
        check({14'h0000, tx_out, core_rx}, 16'h0002);
        @(posedge clk);
        rx_in <= 1'b0;
        core_tx <= 1'b1;
        settle(6);
        check({14'h0000, tx_out, core_rx}, 16'h0001);
        wr(7'h25, 8'h00);
        check({14'h0000, tx_out, core_rx}, 16'h0002);
        for (int i = 0; i < 4; i++) begin
            e = 2'(i);
            wr(7'h26, {4'h0, e[0], e[1], e});
            rd(7'h26, {4'h0, e[0], e[1], e});
            check({12'h000, cfg[11:8]}, {12'h000, e[0], e[1], e});
        end
        wr(7'h27, 8'h80);
        @(posedge clk);
        conf_sample <= 16'sh4000;
        settle(2);
        check(conf_scaled, 16'h2000);
        wr(7'h27, 8'hFF);
        @(posedge clk);
        conf_sample <= 16'shFF00;
        settle(2);
        check(conf_scaled, 16'hFF01);
        wr(7'h24, 8'h00);
        check(16'(hr_n + sr_n), 16'h0000);
        wr(7'h24, 8'h25);
        check(16'(sr_n), 16'h0001);
        check({12'h000, soft_reset_chan}, 16'h0005);
        rd(7'h27, 8'hFF);
        rd(7'h24, 8'h3C);
        wr(7'h21, 8'h55);
        rd(7'h21, 8'h00);
        rd(7'h28, 8'h00);
        wr(7'h22, 8'h07);
        wr(7'h24, 8'hA0);
        check(16'(hr_n), 16'h0001);
        check(16'(sr_n), 16'h0001);
        rd(7'h22, 8'h40);
        rd(7'h27, 8'h00);
        rd(7'h23, 8'h02);
        wr(7'h22, 8'h1F);
        gci_mode <= 1'b1;
        settle(300);
        check({2'b00, mclk_khz}, 16'h1000);
        check({13'h0000, cfg.slot_offset}, 16'h0000);
        dcl_half = 10;
        settle(300);
        check({2'b00, mclk_khz}, 16'h0800);
        print_verdict();
    end
endmodule : test_codec_global_config_regs

`default_nettype wire
